// >>> logic/fail_safe_monitor_pkg.sv
// Package with register map, field layout, reset values and timing constants of the clock monitor.
package fail_safe_monitor_pkg;

  // Register byte offsets on the APB bus.
  localparam logic [7:0] OFS_OSC_CONTROL = 8'h00;
  localparam logic [7:0] OFS_OSC_STATUS = 8'h04;
  localparam logic [7:0] OFS_IRQ_ENABLE_TWO = 8'h08;
  localparam logic [7:0] OFS_IRQ_FLAG_TWO = 8'h0c;
  localparam logic [7:0] OFS_SYS_CONTROL = 8'h10;

  // Field positions.
  localparam int IFS_LSB = 3;
  localparam int IFS_MSB = 6;
  localparam int CSS_LSB = 0;
  localparam int CSS_MSB = 1;
  localparam int STAT_SEC_READY = 7;
  localparam int STAT_STARTUP_DONE = 5;
  localparam int STAT_HF_READY = 4;
  localparam int STAT_LF_READY = 1;
  localparam int STAT_HF_STABLE = 0;
  localparam int OSC_FAIL_BIT = 7;
  localparam int SYS_SLEEP_BIT = 0;

  // Reset values.
  localparam logic [3:0] IFS_RESET = 4'h7;
  localparam logic [1:0] CSS_RESET = 2'h0;

  // Counts.
  localparam int SAMPLE_DIV = 64;
  localparam int STARTUP_CYCLES = 1024;

  // Oscillator modes from the configuration word.
  localparam logic [2:0] MODE_LP = 3'h0;
  localparam logic [2:0] MODE_XT = 3'h1;
  localparam logic [2:0] MODE_HS = 3'h2;
  localparam logic [2:0] MODE_EC = 3'h3;
  localparam logic [2:0] MODE_INT = 3'h4;
  localparam logic [2:0] MODE_RC = 3'h5;

  // System clock selections driven to the clock mux.
  localparam logic [1:0] SRC_CONFIG = 2'h0;
  localparam logic [1:0] SRC_SECONDARY = 2'h1;
  localparam logic [1:0] SRC_INTERNAL = 2'h2;

  typedef struct packed {
    logic fail_monitor_cfg_enable;
    logic two_speed_cfg_enable;
    logic [2:0] osc_mode_config;
  } fail_safe_monitor_cfg_t;

  typedef struct packed {
    logic secondary_osc_enable;
    logic secondary_osc_ready;
    logic hf_internal_ready;
    logic lf_internal_ready;
    logic hf_internal_stable;
  } fail_safe_monitor_osc_stat_t;

  typedef struct packed {
    logic [1:0] sys_clk_source;
    logic [3:0] internal_freq_select;
    logic [2:0] internal_range;
    logic in_fail_safe;
  } fail_safe_monitor_clk_out_t;

endpackage : fail_safe_monitor_pkg

// >>> logic/fail_safe_monitor_detect.sv
// Fail detector: divided sample clock plus external falling edge latch.
`timescale 1ns/1ps
`default_nettype none
module fail_safe_monitor_detect #(
  parameter int DIV = 64
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ext_clk_sync,
  input wire logic lf_tick,
  input wire logic arm,
  output logic fail_pulse
);
  import fail_safe_monitor_pkg::*;

  localparam int HALF = DIV / 2;
  localparam int CW = $clog2(DIV);

  logic [CW-1:0] div_r;
  logic sample_clk_r;
  logic ext_d_r;
  logic seen_r;
  logic ext_fall;
  logic sample_rise;
  logic sample_fall;

  assign ext_fall = ext_d_r & ~ext_clk_sync;
  assign sample_rise = lf_tick && (div_r == CW'(HALF - 1));
  assign sample_fall = lf_tick && (div_r == CW'(DIV - 1));

  // Sample clock is the low-frequency oscillator divided by the division ratio.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_r <= '0;
      sample_clk_r <= 1'b0;
    end else if (lf_tick) begin
      div_r <= div_r + CW'(1);
      if (sample_rise) begin
        sample_clk_r <= 1'b1;
      end else if (sample_fall) begin
        sample_clk_r <= 1'b0;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ext_d_r <= 1'b0;
    end else begin
      ext_d_r <= ext_clk_sync;
    end
  end

  // Falling external edges set the latch, sample rising edges clear it.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      seen_r <= 1'b0;
    end else if (ext_fall) begin
      seen_r <= 1'b1;
    end else if (sample_rise) begin
      seen_r <= 1'b0;
    end
  end

  // A whole high half of the sample clock without a falling external edge is a failure.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fail_pulse <= 1'b0;
    end else begin
      fail_pulse <= arm && sample_fall && !seen_r && !ext_fall && sample_clk_r;
    end
  end

endmodule : fail_safe_monitor_detect
`default_nettype wire

// >>> logic/fail_safe_monitor_top.sv
// Fail-safe clock monitor with oscillator control and status registers on APB.
//
// Design decisions made here: the register offsets and the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none
// Functional notes
// - Monitor works only with config enable set
// - Monitor covers all external oscillator modes
// - Sample clock is low-frequency oscillator over 64
// - External falls set latch, sample rises clear
// - Failure: sample half-period without external fall
// - Failure moves clock internal, sets flag
// - Interrupt when flag and enable both set
// - Fallback clock uses current frequency select
// - Stay internal until software switches back
// - Reset, sleep or source change clears condition
// - Source change restarts timer, expiry returns external
// - Flag not clearable while condition persists
// - Detection waits for timer; EC, RC immediate
// - Monitor enable forces two-speed start-up
// - Status bit 5 shows configured clock running
// - Control fields, reset 0111, reserved read zero
// - Source select: 1x internal, 01 secondary
// - Bit 7 secondary ready, one when disabled
// - Bits 4, 1 report internal oscillators ready
// - Bit 0 shows stable 16 MHz oscillator
// - Start-up timer counts 1024 oscillator cycles
// - Any reset clears source select field
module fail_safe_monitor_top #(
  parameter int STARTUP_COUNT = fail_safe_monitor_pkg::STARTUP_CYCLES,
  parameter int SAMPLE_RATIO = fail_safe_monitor_pkg::SAMPLE_DIV
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire fail_safe_monitor_pkg::fail_safe_monitor_cfg_t cfg,
  input wire fail_safe_monitor_pkg::fail_safe_monitor_osc_stat_t osc_stat_pin,
  input wire logic ext_clk_pin,
  input wire logic lf_clk_pin,
  input wire logic sleep_exec,
  input wire logic wake_event,
  output fail_safe_monitor_pkg::fail_safe_monitor_clk_out_t clk_out,
  output logic osc_fail_irq
);
  import fail_safe_monitor_pkg::*;

  localparam int TW = $clog2(STARTUP_COUNT + 1);

  typedef enum logic [3:0] {
    ST_STARTUP = 4'b0001,
    ST_EXTERNAL = 4'b0010,
    ST_FAILSAFE = 4'b0100,
    ST_SLEEP = 4'b1000
  } fail_safe_monitor_state_t;

  ////////////////////////////////////////////////////////////////////////////////
  // Synchronisers for asynchronous inputs.

  logic [1:0] ext_s_r;
  logic [1:0] lf_s_r;
  logic lf_d_r;
  fail_safe_monitor_osc_stat_t stat_s1_r;
  fail_safe_monitor_osc_stat_t stat_s2_r;
  logic [1:0] sleep_s_r;
  logic [1:0] wake_s_r;
  logic sleep_d_r;
  logic wake_d_r;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ext_s_r <= '0;
      lf_s_r <= '0;
      lf_d_r <= 1'b0;
      stat_s1_r <= '0;
      stat_s2_r <= '0;
      sleep_s_r <= '0;
      wake_s_r <= '0;
      sleep_d_r <= 1'b0;
      wake_d_r <= 1'b0;
    end else begin
      ext_s_r <= {ext_s_r[0], ext_clk_pin};
      lf_s_r <= {lf_s_r[0], lf_clk_pin};
      lf_d_r <= lf_s_r[1];
      stat_s1_r <= osc_stat_pin;
      stat_s2_r <= stat_s1_r;
      sleep_s_r <= {sleep_s_r[0], sleep_exec};
      wake_s_r <= {wake_s_r[0], wake_event};
      sleep_d_r <= sleep_s_r[1];
      wake_d_r <= wake_s_r[1];
    end
  end

  logic lf_tick;
  logic sleep_go;
  logic wake_go;
  assign lf_tick = lf_s_r[1] & ~lf_d_r;
  assign sleep_go = sleep_s_r[1] & ~sleep_d_r;
  assign wake_go = wake_s_r[1] & ~wake_d_r;

  ////////////////////////////////////////////////////////////////////////////////
  // Registers.

  logic [3:0] ifs_r;
  logic [1:0] css_r;
  logic irq_en_r;
  logic fail_flag_r;
  logic sleep_sw_r;
  fail_safe_monitor_state_t state_r;
  logic [TW-1:0] tmr_r;
  logic fail_pulse;
  logic wr_en;
  logic addr_ok;
  logic fail_safe_monitor_u_detect_prev_r;
  logic css_change;
  logic needs_timer;

  function automatic logic [2:0] freq_range(input logic [3:0] code);
    // 0: 31 kHz low, 1: 31.25 kHz, 2: 62.5 to 500 kHz, 3..7: 1 to 16 MHz.
    logic [2:0] r;
    r = 3'h2;
    if (code[3:1] == 3'h0) begin
      r = 3'h0;
    end else if (code[3:1] == 3'h1) begin
      r = 3'h1;
    end else if (code >= 4'hb) begin
      r = 3'(code - 4'h8);
    end
    return r;
  endfunction : freq_range

  function automatic logic is_mapped(input logic [7:0] a);
    return a == OFS_OSC_CONTROL || a == OFS_OSC_STATUS || a == OFS_IRQ_ENABLE_TWO ||
      a == OFS_IRQ_FLAG_TWO || a == OFS_SYS_CONTROL;
  endfunction : is_mapped

  assign addr_ok = is_mapped(paddr);
  assign wr_en = psel && penable && pwrite && pready && addr_ok;
  assign css_change = wr_en && paddr == OFS_OSC_CONTROL && pwdata[CSS_MSB:CSS_LSB] != css_r;
  assign needs_timer = cfg.osc_mode_config == MODE_LP || cfg.osc_mode_config == MODE_XT ||
    cfg.osc_mode_config == MODE_HS;

  // Control register: frequency select and clock source select.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ifs_r <= IFS_RESET;
      css_r <= CSS_RESET;
    end else if (wr_en && paddr == OFS_OSC_CONTROL) begin
      ifs_r <= pwdata[IFS_MSB:IFS_LSB];
      css_r <= pwdata[CSS_MSB:CSS_LSB];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_en_r <= 1'b0;
    end else if (wr_en && paddr == OFS_IRQ_ENABLE_TWO) begin
      irq_en_r <= pwdata[OSC_FAIL_BIT];
    end
  end

  // Software sleep request register models the sleep instruction.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sleep_sw_r <= 1'b0;
    end else begin
      sleep_sw_r <= wr_en && paddr == OFS_SYS_CONTROL && pwdata[SYS_SLEEP_BIT];
    end
  end

  // Fail flag: hardware set wins; software clear only outside the fail-safe condition.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fail_flag_r <= 1'b0;
    end else if (fail_pulse) begin
      fail_flag_r <= 1'b1;
    end else if (wr_en && paddr == OFS_IRQ_FLAG_TWO && state_r != ST_FAILSAFE) begin
      fail_flag_r <= pwdata[OSC_FAIL_BIT] & fail_flag_r;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Clock state machine with the start-up timer.

  logic sleep_req;
  assign sleep_req = sleep_go || sleep_sw_r;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_r <= ST_STARTUP;
      tmr_r <= '0;
    end else if (sleep_req) begin
      state_r <= ST_SLEEP;
      tmr_r <= '0;
    end else begin
      unique case (state_r)
        ST_SLEEP: begin
          tmr_r <= '0;
          if (wake_go) begin
            state_r <= ST_STARTUP;
          end
        end
        ST_STARTUP: begin
          if (css_change) begin
            tmr_r <= '0;
          end else if (!needs_timer || tmr_r == TW'(STARTUP_COUNT)) begin
            state_r <= ST_EXTERNAL;
          end else if (ext_s_r[1] & ~fail_safe_monitor_u_detect_prev_r) begin
            tmr_r <= tmr_r + TW'(1);
          end
        end
        ST_EXTERNAL: begin
          if (fail_pulse) begin
            state_r <= ST_FAILSAFE;
          end else if (css_change) begin
            state_r <= ST_STARTUP;
            tmr_r <= '0;
          end
        end
        ST_FAILSAFE: begin
          if (css_change) begin
            state_r <= ST_STARTUP;
            tmr_r <= '0;
          end
        end
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fail_safe_monitor_u_detect_prev_r <= 1'b0;
    end else begin
      fail_safe_monitor_u_detect_prev_r <= ext_s_r[1];
    end
  end

  logic arm;
  assign arm = cfg.fail_monitor_cfg_enable && state_r == ST_EXTERNAL && css_r == SRC_CONFIG;

  fail_safe_monitor_detect #(
    .DIV(SAMPLE_RATIO)
  ) u_detect (
    .pclk(pclk),
    .presetn(presetn),
    .ext_clk_sync(ext_s_r[1]),
    .lf_tick(lf_tick),
    .arm(arm),
    .fail_pulse(fail_pulse)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // Clock selection outputs.

  logic two_speed;
  logic on_config;
  fail_safe_monitor_clk_out_t clk_nxt;
  assign two_speed = cfg.two_speed_cfg_enable || cfg.fail_monitor_cfg_enable;
  assign on_config = css_r == SRC_CONFIG && (state_r == ST_EXTERNAL ||
    (state_r == ST_STARTUP && !two_speed && needs_timer));

  always_comb begin
    clk_nxt.internal_freq_select = ifs_r;
    clk_nxt.internal_range = freq_range(ifs_r);
    clk_nxt.in_fail_safe = state_r == ST_FAILSAFE;
    if (css_r[1] || state_r == ST_FAILSAFE) begin
      clk_nxt.sys_clk_source = SRC_INTERNAL;
    end else if (css_r == SRC_SECONDARY) begin
      clk_nxt.sys_clk_source = SRC_SECONDARY;
    end else if (on_config) begin
      clk_nxt.sys_clk_source = SRC_CONFIG;
    end else begin
      clk_nxt.sys_clk_source = SRC_INTERNAL;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      clk_out <= '{sys_clk_source: SRC_INTERNAL, internal_freq_select: IFS_RESET,
        internal_range: 3'h2, in_fail_safe: 1'b0};
      osc_fail_irq <= 1'b0;
    end else begin
      clk_out <= clk_nxt;
      osc_fail_irq <= fail_flag_r && irq_en_r;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // APB read path, zero wait states.

  logic [7:0] status_v;
  logic [31:0] rdata_nxt;

  always_comb begin
    status_v = 8'h00;
    status_v[STAT_SEC_READY] = stat_s2_r.secondary_osc_enable ? stat_s2_r.secondary_osc_ready : 1'b1;
    status_v[STAT_STARTUP_DONE] = state_r == ST_EXTERNAL && css_r == SRC_CONFIG;
    status_v[STAT_HF_READY] = stat_s2_r.hf_internal_ready;
    status_v[STAT_LF_READY] = stat_s2_r.lf_internal_ready;
    status_v[STAT_HF_STABLE] = stat_s2_r.hf_internal_stable;
    rdata_nxt = 32'h0000_0000;
    unique case (paddr)
      OFS_OSC_CONTROL: rdata_nxt = {24'h00_0000, 1'b0, ifs_r, 1'b0, css_r};
      OFS_OSC_STATUS: rdata_nxt = {24'h00_0000, status_v};
      OFS_IRQ_ENABLE_TWO: rdata_nxt = {24'h00_0000, irq_en_r, 7'h00};
      OFS_IRQ_FLAG_TWO: rdata_nxt = {24'h00_0000, fail_flag_r, 7'h00};
      default: rdata_nxt = 32'h0000_0000;
    endcase
  end

  // Answer in the first access cycle: pready is registered in the setup cycle and is high for that one access cycle only.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end else begin
      pready <= psel && !penable;
      pslverr <= psel && !penable && !is_mapped(paddr);
      prdata <= (psel && !penable && !pwrite) ? rdata_nxt : prdata;
    end
  end

endmodule : fail_safe_monitor_top
`default_nettype wire

// >>> sim/fail_safe_monitor_xosc_model.sv
// Behavioural external oscillator that runs fast, runs slow or stops.
`timescale 1ns/1ps
`default_nettype none
module fail_safe_monitor_xosc_model #(
  parameter int HALF_NS = 50
) (
  input wire logic run,
  input wire logic slow,
  output logic ext_clk_pin
);
  // A dead crystal freezes at its last level, which is what the detector must catch.
  initial begin
    ext_clk_pin = 1'b0;
    forever begin
      #(slow ? 2 * HALF_NS : HALF_NS);
      if (run) begin
        ext_clk_pin = ~ext_clk_pin;
      end
    end
  end
endmodule : fail_safe_monitor_xosc_model
`default_nettype wire

// >>> sim/fail_safe_monitor_top_assertions.sv
// Concurrent checks on the ports of the fail-safe clock monitor.
`timescale 1ns/1ps
`default_nettype none
module fail_safe_monitor_chk #(
  parameter int STARTUP_COUNT = 1024,
  parameter int SAMPLE_RATIO = 64
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire fail_safe_monitor_pkg::fail_safe_monitor_cfg_t cfg,
  input wire fail_safe_monitor_pkg::fail_safe_monitor_osc_stat_t osc_stat_pin,
  input wire logic ext_clk_pin,
  input wire logic lf_clk_pin,
  input wire logic sleep_exec,
  input wire logic wake_event,
  input wire fail_safe_monitor_pkg::fail_safe_monitor_clk_out_t clk_out,
  input wire logic osc_fail_irq
);
  import fail_safe_monitor_pkg::*;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic ext_d_r, lf_d_r, ctl_wr_r;
  logic [7:0] lf_cnt_r;
  wire rd_stat = pready && !pwrite && paddr == OFS_OSC_STATUS;
  ////////////////////////////////////////////////////////////////
  // Counts low-frequency rises since the last external fall.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ext_d_r <= 1'b0;
      lf_d_r <= 1'b0;
      ctl_wr_r <= 1'b0;
      lf_cnt_r <= 8'h00;
    end else begin
      ext_d_r <= ext_clk_pin;
      lf_d_r <= lf_clk_pin;
      ctl_wr_r <= psel && penable && pwrite && paddr == OFS_OSC_CONTROL;
      if (ext_d_r && !ext_clk_pin) begin
        lf_cnt_r <= 8'h00;
      end else if (!lf_d_r && lf_clk_pin && lf_cnt_r != 8'hff) begin
        lf_cnt_r <= lf_cnt_r + 8'h01;
      end
    end
  end
  ////////////////////////////////////////////////////////////////
  src_on_fail_a: assert property (
    $past(clk_out.in_fail_safe) && clk_out.in_fail_safe |-> clk_out.sys_clk_source == SRC_INTERNAL)
    else $error("Clock not internal in fail-safe.");
  mon_off_a: assert property (
    !cfg.fail_monitor_cfg_enable |-> !clk_out.in_fail_safe) else $error("Fail-safe while monitor off.");
  quiet_fail_a: assert property (
    $rose(clk_out.in_fail_safe) |-> lf_cnt_r >= SAMPLE_RATIO / 2) else $error("Failure declared too early.");
  ctl_rsvd_a: assert property (
    pready && !pwrite && paddr == OFS_OSC_CONTROL |-> prdata[31:7] == 25'h000_0000 && !prdata[2])
    else $error("Control reserved bits not zero.");
  stat_rsvd_a: assert property (
    rd_stat |-> prdata[31:8] == 24'h00_0000 && !prdata[6] && prdata[3:2] == 2'h0)
    else $error("Status reserved bits not zero.");
  sec_ready_a: assert property (
    rd_stat && !osc_stat_pin.secondary_osc_enable && $past(osc_stat_pin.secondary_osc_enable, 4) == 1'b0
    |-> prdata[7]) else $error("Secondary ready not forced.");
  ready_pulse_a: assert property (
    pready |-> psel && penable ##1 !pready) else $error("Ready not a single access pulse.");
  unmapped_err_a: assert property (
    pready && paddr > OFS_SYS_CONTROL |-> pslverr) else $error("Unmapped access not refused.");
  freq_write_a: assert property (
    $changed(clk_out.internal_freq_select) |-> ctl_wr_r || $past(ctl_wr_r))
    else $error("Frequency select changed without write.");
  cv_fail: cover property ($rose(clk_out.in_fail_safe));
  cv_clear: cover property ($fell(clk_out.in_fail_safe));
  cv_irq: cover property ($rose(osc_fail_irq));
  cv_err: cover property (pslverr);
endmodule : fail_safe_monitor_chk
bind fail_safe_monitor_top fail_safe_monitor_chk #(.STARTUP_COUNT(STARTUP_COUNT), .SAMPLE_RATIO(SAMPLE_RATIO)) i_fail_safe_monitor_chk (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .cfg(cfg),
  .osc_stat_pin(osc_stat_pin), .ext_clk_pin(ext_clk_pin), .lf_clk_pin(lf_clk_pin),
  .sleep_exec(sleep_exec), .wake_event(wake_event), .clk_out(clk_out), .osc_fail_irq(osc_fail_irq));
`default_nettype wire

// >>> sim/tb_fail_safe_monitor_top.sv
// Self-checking testbench for the fail-safe clock monitor.
`timescale 1ns/1ps
`default_nettype none
module tb_fail_safe_monitor_top;
  import fail_safe_monitor_pkg::*;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
  logic run, slow, ext_clk_pin, lf_clk_pin, sleep_exec, wake_event, osc_fail_irq;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  fail_safe_monitor_cfg_t cfg;
  fail_safe_monitor_osc_stat_t osc_stat_pin;
  fail_safe_monitor_clk_out_t clk_out;
  int bad_count = 0;
  int n_tests = 0;
  int cyc = 0;
  int waited;
  fail_safe_monitor_top #(.STARTUP_COUNT(8), .SAMPLE_RATIO(4)) i_fail_safe_monitor_top (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .cfg(cfg),
    .osc_stat_pin(osc_stat_pin), .ext_clk_pin(ext_clk_pin), .lf_clk_pin(lf_clk_pin),
    .sleep_exec(sleep_exec), .wake_event(wake_event), .clk_out(clk_out), .osc_fail_irq(osc_fail_irq));
  fail_safe_monitor_xosc_model i_fail_safe_monitor_xosc_model (.run(run), .slow(slow), .ext_clk_pin(ext_clk_pin));
  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end
  initial begin
    lf_clk_pin = 1'b0;
    forever #100 lf_clk_pin = ~lf_clk_pin;
  end
  ////////////////////////////////////////////////////////////////
  task automatic give_verdict();
    $display("Checks %0d, mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : give_verdict
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    n_tests++;
    if (got !== exp) begin
      bad_count++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(negedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    rd = prdata;
    err = pslverr;
    @(posedge pclk);
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 20) chk("apb_ready", 32'h1, 32'h0);
  endtask : apb
  task automatic rdchk(input string nm, input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(nm, exp, rd);
  endtask : rdchk
  task automatic wait_st(input string nm, input logic fs, input logic [1:0] src, input int lim);
    waited = 0;
    while ({clk_out.in_fail_safe, clk_out.sys_clk_source} !== {fs, src} && waited < lim) begin
      @(posedge pclk);
      waited++;
    end
    chk(nm, {29'h0, fs, src}, {29'h0, clk_out.in_fail_safe, clk_out.sys_clk_source});
  endtask : wait_st
  task automatic do_reset(input logic [2:0] mode, input logic en);
    presetn <= 1'b0;
    cfg <= '{en, 1'b1, mode};
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
  endtask : do_reset
  ////////////////////////////////////////////////////////////////
  task automatic t_regs();
    rdchk("ctrl_rst", OFS_OSC_CONTROL, 32'h0000_0038);
    rdchk("flag_rst", OFS_IRQ_FLAG_TWO, 32'h0000_0000);
    apb(1'b1, OFS_OSC_CONTROL, 32'hffff_ffff);
    rdchk("ctrl_rsvd", OFS_OSC_CONTROL, 32'h0000_007b);
    wait_st("src_int", 1'b0, SRC_INTERNAL, 20);
    chk("ifs_out", 32'h0000_000f, {28'h0, clk_out.internal_freq_select});
    chk("range_out", 32'h0000_0007, {29'h0, clk_out.internal_range});
    apb(1'b1, OFS_OSC_CONTROL, 32'h0000_0039);
    wait_st("src_sec", 1'b0, SRC_SECONDARY, 20);
    rdchk("unmapped", 8'h14, 32'h0000_0000);
    chk("unmapped_err", 32'h1, {31'h0, err});
    apb(1'b1, OFS_OSC_CONTROL, 32'h0000_0038);
    $display("t_regs done");
  endtask : t_regs
  task automatic t_startup();
    osc_stat_pin <= '{1'b1, 1'b0, 1'b1, 1'b1, 1'b0};
    slow <= 1'b1;
    wait_st("ext_up", 1'b0, SRC_CONFIG, 3000);
    chk("ost_len", 32'h1, {31'h0, waited >= 120});
    rdchk("status", OFS_OSC_STATUS, 32'h0000_0032);
    slow <= 1'b0;
    osc_stat_pin <= '{1'b0, 1'b0, 1'b0, 1'b1, 1'b1};
    repeat (4) @(posedge pclk);
    rdchk("status2", OFS_OSC_STATUS, 32'h0000_00a3);
    $display("t_startup done");
  endtask : t_startup
  task automatic t_fail();
    apb(1'b1, OFS_IRQ_ENABLE_TWO, 32'h0000_0080);
    rdchk("ien", OFS_IRQ_ENABLE_TWO, 32'h0000_0080);
    run <= 1'b0;
    wait_st("fail", 1'b1, SRC_INTERNAL, 600);
    chk("fail_ifs", 32'h0000_0007, {28'h0, clk_out.internal_freq_select});
    rdchk("flag_set", OFS_IRQ_FLAG_TWO, 32'h0000_0080);
    chk("irq_on", 32'h1, {31'h0, osc_fail_irq});
    apb(1'b1, OFS_IRQ_FLAG_TWO, 32'h0000_0000);
    rdchk("flag_held", OFS_IRQ_FLAG_TWO, 32'h0000_0080);
    run <= 1'b1;
    repeat (200) @(posedge pclk);
    wait_st("stay_int", 1'b1, SRC_INTERNAL, 0);
    apb(1'b1, OFS_OSC_CONTROL, 32'h0000_003a);
    apb(1'b1, OFS_OSC_CONTROL, 32'h0000_0038);
    wait_st("recover", 1'b0, SRC_CONFIG, 2000);
    apb(1'b1, OFS_IRQ_FLAG_TWO, 32'h0000_0000);
    rdchk("flag_clr", OFS_IRQ_FLAG_TWO, 32'h0000_0000);
    chk("irq_off", 32'h0, {31'h0, osc_fail_irq});
    $display("t_fail done");
  endtask : t_fail
  task automatic t_ec_sleep();
    do_reset(MODE_EC, 1'b1);
    wait_st("ec_ext", 1'b0, SRC_CONFIG, 50);
    run <= 1'b0;
    wait_st("ec_fail", 1'b1, SRC_INTERNAL, 600);
    run <= 1'b1;
    apb(1'b1, OFS_SYS_CONTROL, 32'h0000_0001);
    @(posedge pclk);
    wake_event <= 1'b1;
    wait_st("wake_ext", 1'b0, SRC_CONFIG, 50);
    $display("t_ec_sleep done");
  endtask : t_ec_sleep
  task automatic t_off();
    wake_event <= 1'b0;
    do_reset(MODE_EC, 1'b0);
    wait_st("off_ext", 1'b0, SRC_CONFIG, 50);
    run <= 1'b0;
    repeat (400) @(posedge pclk);
    wait_st("off_nofail", 1'b0, SRC_CONFIG, 0);
    run <= 1'b1;
    $display("t_off done");
  endtask : t_off
  ////////////////////////////////////////////////////////////////
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 20000) begin
      bad_count++;
      give_verdict();
    end
  end
  initial begin
    {psel, penable, pwrite, presetn, slow, sleep_exec, wake_event} = 7'h00;
    run = 1'b1;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
    osc_stat_pin = '{1'b0, 1'b0, 1'b1, 1'b0, 1'b1};
    cfg = '{1'b1, 1'b1, MODE_LP};
    do_reset(MODE_LP, 1'b1);
    t_regs();
    t_startup();
    t_fail();
    t_ec_sleep();
    t_off();
    give_verdict();
  end
endmodule : tb_fail_safe_monitor_top
`default_nettype wire
